/* hdl/ssp_top.sv */
// Operation
// - Peer supplies receive clock; it shifts data in.
// - Idle receive clock level readable in control.
// - Transmit clock input, or driven at quarter rate.
// - Idle transmit clock level readable in control.
// - Float condition releases every output driver.
// - Transmit data floats when no word shifts.
// - Receive frame sync fall starts a receive.
// - Multislot turns receive sync into address line.
// - Transmit frame sync fall starts a transmit.
// - Transmit frame sync is input after reset.
// - Frame direction select drives transmit frame sync.
// - Multislot drives the frame pulse on sync.
// - Shift register bits leave on transmit data.
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Two flip-flop synchroniser for pin inputs
// ------------------------------------------------------------------
module ssp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,          // Block clock.
  input wire logic rst_i,          // Synchronous reset.
  input wire logic [W-1:0] d_i,    // Asynchronous levels.
  output logic [W-1:0] q_o         // Synchronised levels.
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ------------------------------------------------------------------
// Word FIFO between the register bus and the transmitter
// ------------------------------------------------------------------
module ssp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk_i,          // Block clock.
  input wire logic rst_i,          // Synchronous reset.
  input wire logic in_valid_i,     // Push request.
  output logic in_ready_o,         // Room for a word.
  input wire logic [W-1:0] in_data_i, // Pushed word.
  output logic out_valid_o,        // A word is waiting.
  input wire logic out_ready_i,    // Pop request.
  output logic [W-1:0] out_data_o  // Oldest word.
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count.
  assign in_ready_o = cnt_r != (AW+1)'(D);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end

  // Depth is a power of two, so the pointers wrap by themselves.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// Serial port top
// ------------------------------------------------------------------
module ssp_top (
  input wire logic clk_i,                  // Machine clock, 250 MHz.
  input wire logic rst_i,                  // Synchronous reset, high.
  input wire logic [ssp_pkg::AVS_AW-1:0] avs_address_i, // Byte address.
  input wire logic avs_read_i,             // Read request.
  input wire logic avs_write_i,            // Write request.
  input wire logic [ssp_pkg::AVS_DW-1:0] avs_writedata_i, // Write data.
  output logic [ssp_pkg::AVS_DW-1:0] avs_readdata_o, // Read data.
  output logic avs_waitrequest_o,          // Low for the answer.
  input wire logic rx_bit_clock_i,         // Receive bit clock pin.
  input wire logic rx_serial_in_i,         // Receive data pin.
  input wire logic rx_frame_sync_i,        // Receive sync or address in.
  output logic multislot_address_line_o,   // Address out.
  output logic multislot_address_line_oe_n_o, // Address enable, low.
  input wire logic tx_bit_clock_i,         // Transmit clock pin in.
  output logic tx_bit_clock_o,             // Transmit clock out.
  output logic tx_bit_clock_oe_n_o,        // Clock enable, low.
  output logic tx_serial_out_o,            // Transmit data out.
  output logic tx_serial_out_oe_n_o,       // Data enable, low.
  input wire logic tx_frame_sync_i,        // Transmit sync pin in.
  output logic tx_frame_sync_o,            // Sync or frame pulse out.
  output logic tx_frame_sync_oe_n_o,       // Sync enable, low.
  input wire logic test_reset_i,           // Test reset pin.
  input wire logic emulation_pin_a_i,      // First emulation pin.
  input wire logic emulation_float_pin_i   // Float pin, active low.
);
  import ssp_pkg::*;

  logic [SYNC_W-1:0] pin_s;
  logic tst_s, emu_a_s, emu_f_s, rxc_s, rxfs_s, rxd_s, txci_s, txfsi_s;
  logic float_r;
  ssp_ctrl_t ctrl_r;
  logic [MS_ADDR_W-1:0] tx_addr_r;
  logic [MS_ADDR_W-1:0] rx_addr_r;
  logic wait_r;
  logic [AVS_DW-1:0] rdata_r;
  logic req, take, ack, push_ok;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;
  logic div_cnt_r, div_r, txc, txc_prev_r, tx_rise, tx_fall;
  logic rxc_prev_r, rx_fall;
  logic fs_drive, fs_out_r, txfs, txfs_prev_r, tx_start;
  logic [WORD_W-1:0] tx_shift_r;
  logic [MS_ADDR_W-1:0] addr_sh_r;
  logic [CNT_W-1:0] tx_cnt_r;
  logic tx_busy_r, txd_r, addr_out_r, addr_drv_r;
  logic rxfs_src, rxfs_prev_r, rx_start, rx_busy_r, rx_full_r;
  logic [CNT_W-1:0] rx_cnt_r;
  logic [WORD_W-1:0] rx_shift_r;
  logic [WORD_W-1:0] rx_data_r;
  logic rx_done;
  logic clk_oe_n_r, dat_oe_n_r, fs_oe_n_r, adr_oe_n_r, txc_out_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and float decode
  // ----------------------------------------------------------------
  ssp_sync #(.W(SYNC_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({test_reset_i, emulation_pin_a_i, emulation_float_pin_i,
          rx_bit_clock_i, rx_frame_sync_i, rx_serial_in_i,
          tx_bit_clock_i, tx_frame_sync_i}),
    .q_o(pin_s)
  );
  assign {tst_s, emu_a_s, emu_f_s, rxc_s, rxfs_s, rxd_s, txci_s,
          txfsi_s} = pin_s;

  // Float needs test reset low, first emulation pin high, float pin low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      float_r <= 1'b0;
    end else begin
      float_r <= !tst_s && emu_a_s && !emu_f_s;
    end
  end

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  // A push to a full FIFO holds waitrequest, so back-pressure reaches
  // software instead of dropping words.
  assign req = avs_read_i || avs_write_i;
  assign push_ok = !(avs_write_i && avs_address_i == REG_TXDATA) ||
                   fifo_in_ready;
  assign take = req && wait_r && push_ok;
  assign ack = req && !wait_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !take;
    end
  end

  // Read data is latched as waitrequest falls and stands for that cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (take && avs_read_i) begin
      rdata_r <= '0;
      case (avs_address_i)
        REG_CTRL: begin
          rdata_r[CTRL_W-1:0] <= ctrl_r;
          rdata_r[LVL_RX_BIT] <= rxc_s;
          rdata_r[LVL_TX_BIT] <= txc;
        end
        REG_RXDATA: rdata_r[WORD_W-1:0] <= rx_data_r;
        REG_STATUS: begin
          rdata_r[ST_RX_FULL] <= rx_full_r;
          rdata_r[ST_TX_BUSY] <= tx_busy_r;
          rdata_r[ST_FIFO_EMPTY] <= !fifo_out_valid;
          rdata_r[ST_FIFO_FULL] <= !fifo_in_ready;
          rdata_r[ST_RX_BUSY] <= rx_busy_r;
        end
        REG_ADDR: rdata_r[2*MS_ADDR_W-1:0] <= {rx_addr_r, tx_addr_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  // Control and address writes land on the answering edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      tx_addr_r <= ADDR_RST;
    end else if (ack && avs_write_i) begin
      if (avs_address_i == REG_CTRL) begin
        ctrl_r <= ssp_ctrl_t'(avs_writedata_i[CTRL_W-1:0]);
      end
      if (avs_address_i == REG_ADDR) begin
        tx_addr_r <= avs_writedata_i[MS_ADDR_W-1:0];
      end
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

  ssp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_txfifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(ack && avs_write_i && avs_address_i == REG_TXDATA),
    .in_ready_o(fifo_in_ready),
    .in_data_i(avs_writedata_i[WORD_W-1:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Bit clocks and edge detection
  // ----------------------------------------------------------------
  // Free-running divider; switching the source may give one odd edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= 1'b0;
      div_r <= 1'b0;
    end else if (div_cnt_r == DIV_LAST) begin
      div_cnt_r <= 1'b0;
      div_r <= !div_r;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  assign txc = ctrl_r.csrc ? div_r : txci_s;
  assign tx_rise = txc && !txc_prev_r;
  assign tx_fall = !txc && txc_prev_r;
  assign rx_fall = !rxc_s && rxc_prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txc_prev_r <= 1'b0;
      rxc_prev_r <= 1'b0;
    end else begin
      txc_prev_r <= txc;
      rxc_prev_r <= rxc_s;
    end
  end

  // ----------------------------------------------------------------
  // Transmit frame sync and transmitter
  // ----------------------------------------------------------------
  assign fs_drive = ctrl_r.fdir || ctrl_r.ms;
  assign txfs = fs_drive ? fs_out_r : txfsi_s;
  // The sync is sampled only on bit clock falls, never on clk_i alone.
  assign tx_start = tx_fall && txfs_prev_r && !txfs && !tx_busy_r &&
                    fifo_out_valid;
  assign fifo_pop = tx_start;

  // A driven sync is one bit clock low, launched when a word waits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_out_r <= 1'b1;
    end else if (tx_rise) begin
      if (!fs_out_r) begin
        fs_out_r <= 1'b1;
      end else if (fs_drive && !tx_busy_r && fifo_out_valid) begin
        fs_out_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txfs_prev_r <= 1'b1;
    end else if (tx_fall) begin
      txfs_prev_r <= txfs;
    end
  end

  // Bits leave MSB first on rises; the peer samples on falls.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_busy_r <= 1'b0;
      tx_shift_r <= '0;
      addr_sh_r <= '0;
      tx_cnt_r <= '0;
      txd_r <= 1'b0;
      addr_out_r <= 1'b0;
      addr_drv_r <= 1'b0;
    end else if (tx_start) begin
      tx_busy_r <= 1'b1;
      tx_shift_r <= fifo_out_data;
      addr_sh_r <= tx_addr_r;
      tx_cnt_r <= '0;
    end else if (tx_rise && tx_busy_r) begin
      if (tx_cnt_r == TX_LAST) begin
        tx_busy_r <= 1'b0;
        addr_drv_r <= 1'b0;
      end else begin
        txd_r <= tx_shift_r[WORD_W-1];
        tx_shift_r <= {tx_shift_r[WORD_W-2:0], 1'b0};
        addr_out_r <= addr_sh_r[MS_ADDR_W-1];
        addr_sh_r <= {addr_sh_r[MS_ADDR_W-2:0], 1'b0};
        addr_drv_r <= tx_cnt_r < ADDR_BITS;
        tx_cnt_r <= tx_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // In multislot mode the frame pulse on the transmit sync frames both.
  assign rxfs_src = ctrl_r.ms ? txfs : rxfs_s;
  assign rx_start = rx_fall && rxfs_prev_r && !rxfs_src &&
                    !rx_busy_r;
  assign rx_done = rx_fall && rx_busy_r && rx_cnt_r == RX_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxfs_prev_r <= 1'b1;
      rx_busy_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_shift_r <= '0;
      rx_addr_r <= '0;
      rx_data_r <= '0;
    end else if (rx_fall) begin
      rxfs_prev_r <= rxfs_src;
      if (rx_start) begin
        rx_busy_r <= 1'b1;
        rx_cnt_r <= '0;
      end else if (rx_busy_r) begin
        rx_shift_r <= {rx_shift_r[WORD_W-2:0], rxd_s};
        if (ctrl_r.ms && rx_cnt_r < ADDR_BITS && !addr_drv_r) begin
          rx_addr_r <= {rx_addr_r[MS_ADDR_W-2:0], rxfs_s};
        end
        rx_cnt_r <= rx_cnt_r + 1'b1;
        if (rx_done) begin
          rx_busy_r <= 1'b0;
          rx_data_r <= {rx_shift_r[WORD_W-2:0], rxd_s};
        end
      end
    end
  end

  // A word that lands as software reads the last one keeps the flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_full_r <= 1'b0;
    end else if (rx_done) begin
      rx_full_r <= 1'b1;
    end else if (ack && avs_read_i && avs_address_i == REG_RXDATA) begin
      rx_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Enables are active low and every one is released while floating.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_oe_n_r <= 1'b1;
      dat_oe_n_r <= 1'b1;
      fs_oe_n_r <= 1'b1;
      adr_oe_n_r <= 1'b1;
      txc_out_r <= 1'b0;
    end else begin
      clk_oe_n_r <= float_r || !ctrl_r.csrc;
      dat_oe_n_r <= float_r || !tx_busy_r;
      fs_oe_n_r <= float_r || !fs_drive;
      adr_oe_n_r <= float_r || !ctrl_r.ms || !addr_drv_r;
      txc_out_r <= div_r;
    end
  end

  assign tx_bit_clock_o = txc_out_r;
  assign tx_bit_clock_oe_n_o = clk_oe_n_r;
  assign tx_serial_out_o = txd_r;
  assign tx_serial_out_oe_n_o = dat_oe_n_r;
  assign tx_frame_sync_o = fs_out_r;
  assign tx_frame_sync_oe_n_o = fs_oe_n_r;
  assign multislot_address_line_o = addr_out_r;
  assign multislot_address_line_oe_n_o = adr_oe_n_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_div_cycle;
    ##2 $fell(div_r) ##2 $rose(div_r);
  endsequence
  sequence s_tx_loaded;
    tx_busy_r && tx_cnt_r == '0;
  endsequence

  AST_FLOAT_HIZ: assert property (float_r |=> tx_bit_clock_oe_n_o &&
    tx_serial_out_oe_n_o && tx_frame_sync_oe_n_o &&
    multislot_address_line_oe_n_o) else $error("output driven in float");
  AST_TXD_HIZ: assert property (!tx_busy_r |=>
    tx_serial_out_oe_n_o) else $error("data driven while idle");
  AST_TXCLK_IN: assert property (!ctrl_r.csrc |=>
    tx_bit_clock_oe_n_o) else $error("clock driven as input");
  AST_TXCLK_QUARTER: assert property ($rose(div_r) |->
    s_div_cycle) else $error("clock not a quarter rate");
  AST_TXCLK_PIN: assert property (ctrl_r.csrc && !float_r |=>
    !tx_bit_clock_oe_n_o && tx_bit_clock_o == $past(div_r))
    else $error("driven clock wrong");
  AST_FS_IN: assert property (!fs_drive |=>
    tx_frame_sync_oe_n_o) else $error("sync driven as input");
  AST_FS_OUT: assert property (fs_drive && !float_r |=>
    !tx_frame_sync_oe_n_o) else $error("sync not driven");
  AST_ADDR_HIZ: assert property (!ctrl_r.ms |=>
    multislot_address_line_oe_n_o) else $error("address line driven");
  AST_TX_START: assert property (tx_start |=> s_tx_loaded ##0
    tx_shift_r == $past(fifo_out_data)) else $error("transmit not started");
  AST_TX_SHIFT: assert property (tx_busy_r && tx_rise &&
    tx_cnt_r != TX_LAST |=> tx_serial_out_o == $past(tx_shift_r[WORD_W-1]))
    else $error("wrong bit shifted out");
  AST_RX_START: assert property (rx_start |=> rx_busy_r &&
    rx_cnt_r == '0) else $error("receive not started");
  AST_RX_SHIFT: assert property (rx_busy_r && rx_fall && !rx_done |=>
    rx_shift_r[0] == $past(rxd_s)) else $error("receive bit lost");
  AST_LEVEL_RD: assert property (take && avs_read_i &&
    avs_address_i == REG_CTRL |=> avs_readdata_o[LVL_RX_BIT] ==
    $past(rxc_s) && avs_readdata_o[LVL_TX_BIT] == $past(txc))
    else $error("clock level readback wrong");
  AST_FS_EDGE: assert property (tx_start |-> txfs_prev_r ##1
    !txfs_prev_r) else $error("start without sync fall");
endmodule
`default_nettype wire

/* hdl/ssp_pkg.sv */
`default_nettype none
package ssp_pkg;
  // ----------------------------------------------------------------
  // Word, bus and register map
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int AVS_AW = 5;
  localparam int AVS_DW = 32;
  localparam int CTRL_W = 3;
  localparam int MS_ADDR_W = 8;
  localparam int CNT_W = 5;
  localparam int SYNC_W = 8;
  localparam logic [AVS_AW-1:0] REG_CTRL = 5'h00;
  localparam logic [AVS_AW-1:0] REG_TXDATA = 5'h04;
  localparam logic [AVS_AW-1:0] REG_RXDATA = 5'h08;
  localparam logic [AVS_AW-1:0] REG_STATUS = 5'h0C;
  localparam logic [AVS_AW-1:0] REG_ADDR = 5'h10;
  // Level bits in the control register and status bit positions.
  localparam int LVL_RX_BIT = 4;
  localparam int LVL_TX_BIT = 5;
  localparam int ST_RX_FULL = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_FIFO_EMPTY = 2;
  localparam int ST_FIFO_FULL = 3;
  localparam int ST_RX_BUSY = 4;
  // ----------------------------------------------------------------
  // Timing and counts
  // ----------------------------------------------------------------
  // Machine clock is clk_i; the driven transmit clock is a quarter of it.
  localparam int TXCLK_DIV = 4;
  localparam logic DIV_LAST = 1'(TXCLK_DIV / 2 - 1);
  localparam logic [CNT_W-1:0] TX_LAST = 5'h10;
  localparam logic [CNT_W-1:0] RX_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] ADDR_BITS = 5'h08;
  // ----------------------------------------------------------------
  // Types and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ms;   // Multislot mode select.
    logic fdir; // Transmit frame sync driven by the device.
    logic csrc; // Transmit bit clock driven by the device.
  } ssp_ctrl_t;
  localparam ssp_ctrl_t CTRL_RST = 3'h0;
  localparam logic [MS_ADDR_W-1:0] ADDR_RST = 8'h00;
endpackage
`default_nettype wire

/* bench/ssp_peer.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Far-side serial peer
// ----------------------------------------------------------------
module ssp_peer (
  output logic rx_bit_clock_o,   // Receive bit clock to the device.
  output logic rx_serial_in_o,   // Receive data to the device.
  output logic rx_frame_sync_o,  // Receive frame sync, idle high.
  output logic tx_bit_clock_o,   // Transmit bit clock to the device.
  output logic tx_frame_sync_o,  // Transmit frame sync, idle high.
  input wire logic tx_serial_out_i // Transmit data from the device.
);
  // Clocks stand still between frames at the level the bench sets.
  initial begin
    rx_bit_clock_o = 1'b0;
    tx_bit_clock_o = 1'b0;
    rx_frame_sync_o = 1'b1;
    tx_frame_sync_o = 1'b1;
    rx_serial_in_o = 1'b0;
  end

  // Idle levels let the bench read the pins back through the device.
  task set_idle(input logic rl, input logic tl);
    rx_bit_clock_o = rl;
    tx_bit_clock_o = tl;
  endtask

  // One full-duplex frame: a high sync sample, a low one, 16 bits, a tail.
  // Data changes just after a rise and is captured at the fall.
  task frame(input logic [15:0] w, output logic [15:0] cap);
    for (int c = 0; c < 19; c++) begin
      rx_bit_clock_o = 1'b1;
      tx_bit_clock_o = 1'b1;
      #1;
      rx_frame_sync_o = (c != 1);
      tx_frame_sync_o = (c != 1);
      if (c >= 2 && c < 18) begin
        rx_serial_in_o = w[17-c];
      end else begin
        rx_serial_in_o = ~rx_serial_in_o;
      end
      #79;
      rx_bit_clock_o = 1'b0;
      tx_bit_clock_o = 1'b0;
      if (c >= 2 && c < 18) begin
        cap[17-c] = tx_serial_out_i;
      end
      #80;
    end
  endtask
endmodule
`default_nettype wire

/* bench/ssp_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end

// ----------------------------------------------------------------
// Testbench top
// ----------------------------------------------------------------
module ssp_top_tb_top;
  import ssp_pkg::*;
  logic clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [AVS_AW-1:0] avs_address_i;
  logic [AVS_DW-1:0] avs_writedata_i, avs_readdata_o, q;
  logic rx_bit_clock_i, rx_serial_in_i, rx_frame_sync_i;
  logic multislot_address_line_o, multislot_address_line_oe_n_o;
  logic tx_bit_clock_i, tx_bit_clock_o, tx_bit_clock_oe_n_o;
  logic tx_serial_out_o, tx_serial_out_oe_n_o;
  logic tx_frame_sync_i, tx_frame_sync_o, tx_frame_sync_oe_n_o;
  logic test_reset_i, emulation_pin_a_i, emulation_float_pin_i;
  logic [15:0] cap;
  logic a, b, c;
  int err_total = 0;
  int n_checks = 0;

  ssp_top dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .rx_bit_clock_i,
    .rx_serial_in_i, .rx_frame_sync_i, .multislot_address_line_o,
    .multislot_address_line_oe_n_o, .tx_bit_clock_i, .tx_bit_clock_o,
    .tx_bit_clock_oe_n_o, .tx_serial_out_o, .tx_serial_out_oe_n_o,
    .tx_frame_sync_i, .tx_frame_sync_o, .tx_frame_sync_oe_n_o, .test_reset_i,
    .emulation_pin_a_i, .emulation_float_pin_i);

  ssp_peer u_peer (.rx_bit_clock_o(rx_bit_clock_i),
    .rx_serial_in_o(rx_serial_in_i), .rx_frame_sync_o(rx_frame_sync_i),
    .tx_bit_clock_o(tx_bit_clock_i), .tx_frame_sync_o(tx_frame_sync_i),
    .tx_serial_out_i(tx_serial_out_oe_n_o ? ~tx_serial_out_o :
      tx_serial_out_o));
  // A released data line shows the inverse, so a late enable spoils it.

  // 250 MHz machine clock.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Verdict and end of run, shared by the tests and the watchdog.
  task results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One Avalon transfer; the request holds until waitrequest is seen low.
  // Right after a rise the bus still shows what that rise sampled, so the
  // answer is taken there and released at once; one more edge of request
  // would let the slave take it a second time.
  task av(input logic w, input logic [AVS_AW-1:0] ad,
          input logic [AVS_DW-1:0] d, output logic [AVS_DW-1:0] rq);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_address_i <= ad;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 5000) begin
        err_total++;
        results;
      end
    end while (avs_waitrequest_o !== 1'b0);
    rq = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  // Transmit word pattern; its inverse is what the peer sends back.
  function automatic logic [15:0] tw(input int i);
    return 16'h0F0F ^ 16'(i * 16'h1111);
  endfunction

  // Hangs are cut short well past the expected run time.
  initial begin
    #80000;
    err_total++;
    results;
  end

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0000_0000;
    test_reset_i = 1'b0;
    emulation_pin_a_i = 1'b0;
    emulation_float_pin_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    av(1'b0, REG_CTRL, 32'h0, q);
    `CHK("ctrl_rst", 32'h0000_0000, q)
    `CHK("fs_dir_rst", 1'b1, tx_frame_sync_oe_n_o)
    `CHK("dx_idle", 1'b1, tx_serial_out_oe_n_o)
    // Unmapped place: write ignored, read gives zero.
    av(1'b1, 5'h14, 32'hFFFF_FFFF, q);
    av(1'b0, 5'h14, 32'h0, q);
    `CHK("unmapped", 32'h0000_0000, q)
    // Idle pin levels read back; the loop ends with both clocks low.
    for (int i = 3; i >= 0; i--) begin
      u_peer.set_idle(i[0], i[1]);
      repeat (8) @(posedge clk_i);
      av(1'b0, REG_CTRL, 32'h0, q);
      `CHK("lvl", 2'(i), q[LVL_TX_BIT:LVL_RX_BIT])
    end
    // Fill the FIFO to its limit, then drain it one frame per word
    // with the peer stalling between frames.
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      av(1'b1, REG_TXDATA, 32'(tw(i)), q);
    end
    av(1'b0, REG_STATUS, 32'h0, q);
    `CHK("fifo_full", 1'b1, q[ST_FIFO_FULL])
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      u_peer.frame(~tw(i), cap);
      `CHK("tx_word", tw(i), cap)
      av(1'b0, REG_RXDATA, 32'h0, q);
      `CHK("rx_word", {16'h0000, ~tw(i)}, q)
      repeat (20) @(posedge clk_i);
    end
    av(1'b0, REG_STATUS, 32'h0, q);
    `CHK("fifo_empty", 1'b1, q[ST_FIFO_EMPTY])
    `CHK("dx_released", 1'b1, tx_serial_out_oe_n_o)
    // Device-driven sync on the peer's clock falls one bit clock ahead of
    // the peer's own, so the word lands one place higher and the released
    // line shows the inverse of the last bit.
    av(1'b1, REG_CTRL, 32'h0000_0002, q);
    av(1'b1, REG_TXDATA, 32'h0000_A5C3, q);
    u_peer.frame(16'h0000, cap);
    `CHK("fs_drv_tx", 16'h4B86, cap)
    `CHK("fs_idle", 1'b1, tx_frame_sync_o)
    av(1'b0, REG_STATUS, 32'h0, q);
    `CHK("rx_full", 1'b1, q[ST_RX_FULL])
    av(1'b1, REG_ADDR, 32'h0000_005A, q);
    av(1'b0, REG_ADDR, 32'h0, q);
    `CHK("addr_rw", 32'h0000_005A, q)
    // Device-driven transmit clock and frame sync.
    av(1'b1, REG_CTRL, 32'h0000_0003, q);
    repeat (6) @(posedge clk_i);
    `CHK("clk_drive", 1'b0, tx_bit_clock_oe_n_o)
    `CHK("fs_drive", 1'b0, tx_frame_sync_oe_n_o)
    @(negedge clk_i);
    a = tx_bit_clock_o;
    repeat (2) @(negedge clk_i);
    b = tx_bit_clock_o;
    repeat (2) @(negedge clk_i);
    c = tx_bit_clock_o;
    `CHK("div_half", ~a, b)
    `CHK("div_full", a, c)
    // Float condition releases every driver.
    @(posedge clk_i);
    emulation_pin_a_i <= 1'b1;
    emulation_float_pin_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK("flt_clk", 1'b1, tx_bit_clock_oe_n_o)
    `CHK("flt_fs", 1'b1, tx_frame_sync_oe_n_o)
    `CHK("flt_dx", 1'b1, tx_serial_out_oe_n_o)
    `CHK("flt_addr", 1'b1, multislot_address_line_oe_n_o)
    emulation_pin_a_i <= 1'b0;
    emulation_float_pin_i <= 1'b1;
    // Multislot mode drives the frame pulse line on its own.
    av(1'b1, REG_CTRL, 32'h0000_0004, q);
    repeat (8) @(posedge clk_i);
    `CHK("ms_frame", 1'b0, tx_frame_sync_oe_n_o)
    `CHK("ms_addr_idle", 1'b1, multislot_address_line_oe_n_o)
    av(1'b1, REG_CTRL, 32'h0000_0000, q);
    repeat (8) @(posedge clk_i);
    `CHK("fs_input", 1'b1, tx_frame_sync_oe_n_o)
    results;
  end
endmodule
`default_nettype wire
